/* bcs_defines.svh */
/*
 * Shared constants for the burst configuration and sequencer link.
 * Assumes it is included by its bare name wherever a constant is needed.
 */
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH
`define BCS_CFG_ADDR      8'h01
`define BCS_CFG_RESET     8'h22
`define BCS_BL_LSB        0
`define BCS_BL_MSB        2
`define BCS_BT_BIT        3
`define BCS_WC_BIT        4
`define BCS_WR_LSB        5
`define BCS_WR_MSB        7
`define BCS_BL4           3'h2
`define BCS_BL8           3'h3
`define BCS_BL16          3'h4
`define BCS_WR_MIN_CODE   3'h1
`define BCS_WR_MAX_CODE   3'h6
`define BCS_WR_OFFSET     4'h2
`define BCS_REG_CTRL      32'h0000_0000
`define BCS_REG_CONFIG    32'h0000_0004
`define BCS_REG_STATUS    32'h0000_0008
`define BCS_REG_LASTCOL   32'h0000_000C
`define BCS_REG_TWR       32'h0000_0010
`define BCS_CLK_PERIOD_NS 16'h0032
`define BCS_CMD_MRW       2'h1
`define BCS_CMD_READ      2'h2
`define BCS_CMD_WRITE     2'h3
`define BCS_FULL_X8       12'h3FE
`define BCS_FULL_X16      12'h1FE
`define BCS_FULL_X32      12'h0FE
`define BCS_SUB_A         12'h0FE
`define BCS_SUB_B         12'h1FE
`define BCS_SUB_C         12'h2FE
`define BCS_ORG_X8        2'h1
`define BCS_ORG_X16       2'h2
`define BCS_ORG_X32       2'h0
`endif

/* bcs_pkg.sv */
/*
 * Types shared by both ends of the burst configuration link.
 * Assumes bcs_defines.svh supplies the numeric constants.
 */
package bcs_pkg;
	typedef enum logic [1:0] {
		BCS_CMD_NONE_E  = 2'h0,
		BCS_CMD_MRW_E   = 2'h1,
		BCS_CMD_READ_E  = 2'h2,
		BCS_CMD_WRITE_E = 2'h3
	} bcs_cmd_type;
	typedef enum logic [1:0] {
		BCS_DS_IDLE  = 2'h0,
		BCS_DS_BURST = 2'h1,
		BCS_DS_REC   = 2'h3
	} bcs_dev_state_type;
	typedef enum logic [1:0] {
		BCS_HS_IDLE = 2'h0,
		BCS_HS_ISSUE = 2'h1,
		BCS_HS_WAIT = 2'h3
	} bcs_host_state_type;
endpackage : bcs_pkg

/* bcs_link_if.sv */
/*
 * Command link between controller and device end.
 * Assumes both ends share aclk; the bench joins the two modports.
 */
`timescale 1ns/1ps
interface bcs_link_if;
	logic                   cmd_valid;
	bcs_pkg::bcs_cmd_type   cmd;
	logic [7:0]             mr_addr;
	logic [7:0]             mr_data;
	logic [11:0]            column;
	logic                   auto_precharge;
	logic                   busy;
	logic                   beat_valid;
	logic [11:0]            beat_column;
	logic                   precharge_start;
	modport device (input cmd_valid, input cmd, input mr_addr,
		input mr_data, input column, input auto_precharge,
		output busy, output beat_valid, output beat_column,
		output precharge_start);
	modport host (output cmd_valid, output cmd, output mr_addr,
		output mr_data, output column, output auto_precharge,
		input busy, input beat_valid, input beat_column,
		input precharge_start);
endinterface : bcs_link_if

/* bcs_device.sv */
/*
 * Device end: burst feature register, column sequencer, recovery timer.
 * Assumes commands arrive synchronous to aclk and only while busy is low.
 */
`timescale 1ns/1ps
`include "bcs_defines.svh"
module bcs_device (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	bcs_link_if.device       link,
	output logic      [7:0]  burst_feature_config,
	output logic      [3:0]  write_recovery_count
);
	typedef struct packed {
		bcs_pkg::bcs_dev_state_type st;
		logic [7:0]  cfg;
		logic [11:0] base;
		logic [3:0]  start;
		logic [3:0]  idx;
		logic        ap;
		logic [3:0]  rec;
		logic        bvalid;
		logic [11:0] bcol;
		logic        pre;
	} bcs_dev_type;
	bcs_dev_type s_q;
	bcs_dev_type s_d;
	logic [2:0]  bl_code;
	logic [3:0]  last_idx;
	logic [3:0]  off;
	logic [3:0]  mask;
	logic [3:0]  wr_cnt;
	logic [2:0]  wr_code;
	always_comb begin
		bl_code = s_q.cfg[`BCS_BL_MSB:`BCS_BL_LSB];
		wr_code = s_q.cfg[`BCS_WR_MSB:`BCS_WR_LSB];
		case (bl_code)
		`BCS_BL8:  mask = 4'h7;
		`BCS_BL16: mask = 4'hF;
		default:   mask = 4'h3;
		endcase
		last_idx = mask;
		wr_cnt = {1'b0, wr_code} + `BCS_WR_OFFSET;
		if (s_q.cfg[`BCS_WC_BIT]) begin
			off = s_q.idx;
		end else if (s_q.cfg[`BCS_BT_BIT]) begin
			off = (s_q.start ^ s_q.idx) & mask;
		end else begin
			off = (s_q.start + s_q.idx) & mask;
		end
	end
	always_comb begin
		s_d = s_q;
		s_d.bvalid = 1'b0;
		s_d.pre = 1'b0;
		case (s_q.st)
		bcs_pkg::BCS_DS_IDLE: begin
			if (link.cmd_valid) begin
				if (link.cmd == bcs_pkg::BCS_CMD_MRW_E &&
					link.mr_addr == `BCS_CFG_ADDR) begin
					s_d.cfg = link.mr_data;
				end else if (link.cmd == bcs_pkg::BCS_CMD_READ_E ||
					link.cmd == bcs_pkg::BCS_CMD_WRITE_E) begin
					s_d.st = bcs_pkg::BCS_DS_BURST;
					s_d.base = {link.column[11:1], 1'b0};
					s_d.start = {link.column[3:1], 1'b0};
					s_d.idx = 4'h0;
					s_d.ap = link.auto_precharge &&
						link.cmd == bcs_pkg::BCS_CMD_WRITE_E;
				end
			end
		end
		bcs_pkg::BCS_DS_BURST: begin
			s_d.bvalid = 1'b1;
			if (s_q.cfg[`BCS_WC_BIT]) begin
				s_d.bcol = s_q.base + {8'h00, off};
			end else begin
				s_d.bcol = (s_q.base & ~{8'h00, mask}) | {8'h00, off};
			end
			s_d.idx = s_q.idx + 4'h1;
			if (s_q.idx == last_idx) begin
				s_d.rec = wr_cnt;
				s_d.st = s_q.ap ? bcs_pkg::BCS_DS_REC
					: bcs_pkg::BCS_DS_IDLE;
			end
		end
		bcs_pkg::BCS_DS_REC: begin
			s_d.rec = s_q.rec - 4'h1;
			if (s_q.rec == 4'h1) begin
				s_d.pre = 1'b1;
				s_d.st = bcs_pkg::BCS_DS_IDLE;
			end
		end
		default: s_d.st = bcs_pkg::BCS_DS_IDLE;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.cfg <= `BCS_CFG_RESET;
		end else begin
			s_q <= s_d;
		end
	end
	assign link.busy = s_q.st != bcs_pkg::BCS_DS_IDLE;
	assign link.beat_valid = s_q.bvalid;
	assign link.beat_column = s_q.bcol;
	assign link.precharge_start = s_q.pre;
	assign burst_feature_config = s_q.cfg;
	assign write_recovery_count = wr_cnt;
endmodule : bcs_device

/* bcs_host.sv */
/*
 * Controller end: AXI4-Lite register slave that issues link commands.
 * Assumes software follows the AXI4-Lite handshake on aclk.
 */
`timescale 1ns/1ps
`include "bcs_defines.svh"
module bcs_host #(
	parameter logic [1:0] ORG = `BCS_ORG_X16
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	bcs_link_if.host         link
);
	typedef struct packed {
		bcs_pkg::bcs_host_state_type st;
		logic        aw_got;
		logic        w_got;
		logic [31:0] awa;
		logic [31:0] wd;
		logic        bv;
		logic [1:0]  br;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
		logic [7:0]  cfg;
		logic [15:0] twr_ns;
		logic [13:0] cmd_word;
		logic        refused;
		logic [11:0] last_col;
		logic        cvalid;
	} bcs_host_s_type;
	bcs_host_s_type s_q;
	bcs_host_s_type s_d;
	logic [15:0] wr_cycles;
	logic [2:0]  wr_code;
	logic [2:0]  bl;
	logic        bad_mode;
	logic        bad_col;
	logic [11:0] ccol;
	always_comb begin
		wr_cycles = (s_q.twr_ns + `BCS_CLK_PERIOD_NS - 16'h0001)
			/ `BCS_CLK_PERIOD_NS;
		if (wr_cycles < 16'h0003) wr_code = `BCS_WR_MIN_CODE;
		else if (wr_cycles > 16'h0008) wr_code = `BCS_WR_MAX_CODE;
		else wr_code = 3'(wr_cycles - 16'h0002);
		bl = s_q.cfg[`BCS_BL_MSB:`BCS_BL_LSB];
		bad_mode = (bl != `BCS_BL4 && bl != `BCS_BL8 && bl != `BCS_BL16)
			|| (bl == `BCS_BL16 && s_q.cfg[`BCS_BT_BIT])
			|| (bl != `BCS_BL4 && s_q.cfg[`BCS_WC_BIT]);
		ccol = {s_q.cmd_word[11:1], 1'b0};
		case (ORG)
		`BCS_ORG_X8:  bad_col = ccol == `BCS_FULL_X8 ||
			ccol == `BCS_SUB_A || ccol == `BCS_SUB_B ||
			ccol == `BCS_SUB_C;
		`BCS_ORG_X16: bad_col = ccol == `BCS_FULL_X16 ||
			ccol == `BCS_SUB_A;
		default:      bad_col = ccol == `BCS_FULL_X32;
		endcase
		bad_col = bad_col && s_q.cfg[`BCS_WC_BIT];
	end
	always_comb begin
		s_d = s_q;
		s_d.cvalid = 1'b0;
		if (awvalid && !s_q.aw_got && !s_q.bv) begin
			s_d.aw_got = 1'b1;
			s_d.awa = awaddr;
		end
		if (wvalid && !s_q.w_got && !s_q.bv) begin
			s_d.w_got = 1'b1;
			s_d.wd = wdata;
		end
		if (s_q.bv && bready) s_d.bv = 1'b0;
		if (s_q.rv && rready) s_d.rv = 1'b0;
		if (s_q.aw_got && s_q.w_got && s_q.st == bcs_pkg::BCS_HS_IDLE) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bv = 1'b1;
			s_d.br = 2'h0;
			case (s_q.awa)
			`BCS_REG_CTRL: begin
				s_d.cmd_word = s_q.wd[13:0];
				s_d.st = bcs_pkg::BCS_HS_ISSUE;
			end
			`BCS_REG_CONFIG: begin
				s_d.cfg = s_q.wd[7:0];
				s_d.cmd_word = {`BCS_CMD_MRW, 12'h000};
				s_d.st = bcs_pkg::BCS_HS_ISSUE;
			end
			`BCS_REG_STATUS: if (s_q.wd[1]) s_d.refused = 1'b0;
			`BCS_REG_TWR:    s_d.twr_ns = s_q.wd[15:0];
			default:         s_d.br = 2'h2;
			endcase
		end
		if (arvalid && !s_q.rv) begin
			s_d.rv = 1'b1;
			s_d.rr = 2'h0;
			case (araddr)
			`BCS_REG_CONFIG:  s_d.rd = {24'h0, s_q.cfg};
			`BCS_REG_STATUS:  s_d.rd = {30'h0, s_q.refused,
				link.busy || s_q.st != bcs_pkg::BCS_HS_IDLE};
			`BCS_REG_LASTCOL: s_d.rd = {20'h0, s_q.last_col};
			`BCS_REG_TWR:     s_d.rd = {16'h0, s_q.twr_ns};
			default: begin
				s_d.rd = 32'h0000_0000;
				s_d.rr = 2'h2;
			end
			endcase
		end
		case (s_q.st)
		bcs_pkg::BCS_HS_IDLE: ;
		bcs_pkg::BCS_HS_ISSUE: if (!link.busy) begin
			// An illegal mode is refused before it reaches the device.
			if (bad_mode || (s_q.cmd_word[13:12] != `BCS_CMD_MRW &&
				bad_col)) begin
				s_d.refused = 1'b1;
				s_d.st = bcs_pkg::BCS_HS_IDLE;
			end else begin
				s_d.cvalid = 1'b1;
				s_d.st = bcs_pkg::BCS_HS_WAIT;
			end
		end
		bcs_pkg::BCS_HS_WAIT: if (!s_q.cvalid && !link.busy)
			s_d.st = bcs_pkg::BCS_HS_IDLE;
		default: s_d.st = bcs_pkg::BCS_HS_IDLE;
		endcase
		if (link.beat_valid) s_d.last_col = link.beat_column;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.cfg <= `BCS_CFG_RESET;
		end else begin
			s_q <= s_d;
		end
	end
	assign awready = !s_q.aw_got && !s_q.bv;
	assign wready = !s_q.w_got && !s_q.bv;
	assign bvalid = s_q.bv;
	assign bresp = s_q.br;
	assign arready = !s_q.rv;
	assign rvalid = s_q.rv;
	assign rdata = s_q.rd;
	assign rresp = s_q.rr;
	assign link.cmd_valid = s_q.cvalid;
	assign link.cmd = bcs_pkg::bcs_cmd_type'(s_q.cmd_word[13:12]);
	assign link.mr_addr = `BCS_CFG_ADDR;
	assign link.mr_data = {wr_code, s_q.cfg[4:0]};
	assign link.column = s_q.cmd_word[11:0];
	assign link.auto_precharge = s_q.wd[14];
endmodule : bcs_host

/* bcs_link_properties.sv */
/* Checker for the burst link between the controller and device ends.
   Assumes the link signals are wired in by name, all on aclk. */
`timescale 1ns/1ps
module bcs_link_properties (
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire logic                 cmd_valid,
	input wire bcs_pkg::bcs_cmd_type cmd,
	input wire logic [7:0]           mr_addr,
	input wire logic [7:0]           mr_data,
	input wire logic [11:0]          column,
	input wire logic                 auto_precharge,
	input wire logic                 busy,
	input wire logic                 beat_valid,
	input wire logic [11:0]          beat_column,
	input wire logic                 precharge_start
);
	typedef struct packed {
		logic [7:0]  cfg;
		logic [11:0] start;
		logic [4:0]  idx;
		logic [4:0]  rec;
		logic        wr_ap;
	} bcs_chk_type;
	bcs_chk_type chk_q;
	bcs_chk_type chk_d;
	logic        acc;
	logic        mrw;
	assign acc = cmd_valid && !busy && cmd[1];
	assign mrw = cmd_valid && !busy && cmd == bcs_pkg::BCS_CMD_MRW_E
		&& mr_addr == 8'h01;
	function automatic logic [11:0] beat_col(logic [11:0] c,
		logic [7:0] f, logic [4:0] i);
		logic [11:0] s;
		logic [11:0] m;
		s = c & 12'hFFE;
		m = f[2:0] == 3'h2 ? 12'h003 : f[2:0] == 3'h3 ? 12'h007 : 12'h00F;
		if (f[4])
			return s + {7'h0, i};
		if (f[3])
			return (s & ~m) | ((s ^ {7'h0, i}) & m);
		return (s & ~m) | ((s + {7'h0, i}) & m);
	endfunction : beat_col
	always_comb begin
		chk_d = chk_q;
		if (mrw)
			chk_d.cfg = mr_data;
		if (acc) begin
			chk_d.start = column;
			chk_d.idx = 5'h0;
			chk_d.wr_ap = cmd[0] && auto_precharge;
		end
		if (beat_valid) begin
			chk_d.idx = chk_q.idx + 5'h1;
			chk_d.rec = 5'h1;
		end else if (chk_q.rec != 5'h0 && chk_q.rec != 5'h1F)
			chk_d.rec = chk_q.rec + 5'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			chk_q <= '{cfg: 8'h22, default: '0};
		else
			chk_q <= chk_d;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence four_s; beat_valid [*4] ##1 !beat_valid; endsequence
	sequence eight_s; beat_valid [*8] ##1 !beat_valid; endsequence
	burst_four_a: assert property (acc && chk_q.cfg[2:0] == 3'h2 |->
		##2 four_s) else $error("four beat burst wrong");
	burst_eight_a: assert property (acc && chk_q.cfg[2:0] == 3'h3 |->
		##2 eight_s) else $error("eight beat burst wrong");
	burst_len_a: assert property ($fell(beat_valid) |->
		chk_q.idx == (5'h4 << (chk_q.cfg[2:0] - 3'h2)))
		else $error("burst length wrong");
	beat_order_a: assert property (beat_valid |->
		beat_column == beat_col(chk_q.start, chk_q.cfg, chk_q.idx))
		else $error("beat column wrong");
	start_even_a: assert property (acc |-> ##2 !beat_column[0] &&
		beat_column[11:1] == $past(column[11:1], 2))
		else $error("start column wrong");
	high_fixed_a: assert property (beat_valid && !chk_q.cfg[4] |->
		beat_column[11:4] == chk_q.start[11:4])
		else $error("upper column bits moved");
	precharge_time_a: assert property (precharge_start |->
		chk_q.wr_ap && chk_q.rec == {2'h0, chk_q.cfg[7:5]} + 5'h2)
		else $error("precharge early or unasked");
	precharge_due_a: assert property (chk_q.wr_ap && !beat_valid &&
		chk_q.rec == {2'h0, chk_q.cfg[7:5]} + 5'h2 |-> precharge_start)
		else $error("precharge missing");
	mode_legal_a: assert property (mrw |->
		mr_data[2:0] inside {3'h2, 3'h3, 3'h4} && mr_data[7:5] != 3'h0
		&& mr_data[7:5] != 3'h7 && !(mr_data[3] && mr_data[2:0] == 3'h4)
		&& !(mr_data[4] && mr_data[2:0] != 3'h2))
		else $error("illegal mode written");
	no_straddle_a: assert property (acc && chk_q.cfg[4] |->
		column[7:1] != 7'h7F) else $error("burst straddles boundary");
endmodule : bcs_link_properties

/* testbench.sv */
/* Self-checking bench: AXI4-Lite driver for the controller end, joined
   over the link to the device end. Assumes the designer's register map. */
`timescale 1ns/1ps
`include "bcs_defines.svh"
module testbench;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [7:0]  cfg_o;
	logic [3:0]  nwr_o;
	logic [2:0]  code;
	logic [11:0] q[$];
	int error_cnt, checks, cyc, since, gap;
	bcs_link_if link();
	bcs_device i_bcs_device(.aclk(aclk), .aresetn(aresetn), .link(link),
		.burst_feature_config(cfg_o), .write_recovery_count(nwr_o));
	bcs_host #(.ORG(`BCS_ORG_X16)) i_bcs_host(.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.link(link));
	bcs_link_properties i_props(.aclk(aclk), .aresetn(aresetn),
		.cmd_valid(link.cmd_valid), .cmd(link.cmd), .mr_addr(link.mr_addr),
		.mr_data(link.mr_data), .column(link.column),
		.auto_precharge(link.auto_precharge), .busy(link.busy),
		.beat_valid(link.beat_valid), .beat_column(link.beat_column),
		.precharge_start(link.precharge_start));
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (link.beat_valid === 1'b1) begin
			q.push_back(link.beat_column);
			since = 0;
		end else
			since++;
		if (link.precharge_start === 1'b1)
			gap = since;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic axi_wr(logic [31:0] a, logic [31:0] d, logic [1:0] er);
		bit aw, w, b;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			@(posedge aclk);
			if (!aw && awready === 1'b1) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 1'b0;
			end
			b = bvalid === 1'b1;
		end
		bready <= 1'b0;
		check("write response", 32'(bresp), 32'(er));
	endtask : axi_wr
	task automatic axi_rd(logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit ar;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (!ar && arready === 1'b1) begin
				ar = 1;
				arvalid <= 1'b0;
			end
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	task automatic set_cfg(logic [7:0] cf);
		int k;
		axi_wr(`BCS_REG_CONFIG, {24'h0, cf}, 2'h0);
		while (cfg_o !== {code, cf[4:0]} && k < 30) begin
			@(posedge aclk);
			k++;
		end
		check("config", 32'(cfg_o), 32'({code, cf[4:0]}));
	endtask : set_cfg
	function automatic logic [11:0] beat_col(logic [11:0] c,
		logic [7:0] f, int i);
		logic [11:0] s;
		logic [11:0] m;
		s = c & 12'hFFE;
		m = f[2:0] == 3'h2 ? 12'h003 : f[2:0] == 3'h3 ? 12'h007 : 12'h00F;
		if (f[4])
			return s + 12'(i);
		return (s & ~m) | ((f[3] ? s ^ 12'(i) : s + 12'(i)) & m);
	endfunction : beat_col
	task automatic burst(logic [7:0] cf, logic [11:0] c, logic [1:0] cm,
		logic ap);
		int n, k;
		logic [31:0] d;
		logic [1:0] r;
		n = 4 << (cf[2:0] - 3'h2);
		set_cfg(cf);
		q.delete();
		gap = 0;
		axi_wr(`BCS_REG_CTRL, {17'h0, ap, cm, c}, 2'h0);
		while ((q.size() < n || link.busy !== 1'b0) && k < 100) begin
			@(posedge aclk);
			k++;
		end
		check("beat count", 32'(q.size()), 32'(n));
		foreach (q[i])
			check("beat column", 32'(q[i]), 32'(beat_col(c, cf, i)));
		axi_rd(`BCS_REG_LASTCOL, d, r);
		check("last column", d, 32'(beat_col(c, cf, n - 1)));
	endtask : burst
	task automatic refuse(logic [31:0] a, logic [31:0] v);
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] old;
		old = cfg_o;
		q.delete();
		axi_wr(a, v, 2'h0);
		axi_rd(`BCS_REG_STATUS, d, r);
		check("refused set", 32'(d[1]), 32'h1);
		axi_wr(`BCS_REG_STATUS, 32'h2, 2'h0);
		axi_rd(`BCS_REG_STATUS, d, r);
		check("refused clear", 32'(d[1]), 32'h0);
		check("no beats", 32'(q.size()), 32'h0);
		check("config kept", 32'(cfg_o), 32'(old));
	endtask : refuse
	initial begin
		int write_recovery_time[6] = '{100, 150, 151, 400, 500, 300};
		logic [7:0] modes[6] = '{8'h02, 8'h0A, 8'h03, 8'h0B, 8'h04, 8'h12};
		int e;
		logic [31:0] d;
		logic [1:0] r;
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr} = '0;
		wstrb = 4'hF;
		code = 3'h1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check("reset config", 32'(cfg_o), 32'(`BCS_CFG_RESET));
		check("reset recovery", 32'(nwr_o), 32'h3);
		$display("test reset done");
		foreach (write_recovery_time[i]) begin
			e = (write_recovery_time[i] + 49) / 50;
			e = e < 3 ? 3 : e > 8 ? 8 : e;
			code = 3'(e - 2);
			axi_wr(`BCS_REG_TWR, 32'(write_recovery_time[i]), 2'h0);
			set_cfg(8'h02);
			check("recovery count", 32'(nwr_o), 32'(e));
		end
		$display("test recovery done");
		foreach (modes[i])
			burst(modes[i], 12'h1A7, i[0] ? 2'h3 : 2'h2, 1'b0);
		burst(8'h02, 12'h004, 2'h3, 1'b1);
		repeat (20) @(posedge aclk);
		check("precharge delay", 32'(gap), 32'(code) + 32'h2);
		$display("test bursts done");
		refuse(`BCS_REG_CONFIG, 32'h0C);
		refuse(`BCS_REG_CONFIG, 32'h13);
		refuse(`BCS_REG_CONFIG, 32'h07);
		set_cfg(8'h12);
		refuse(`BCS_REG_CTRL, 32'h21FE);
		refuse(`BCS_REG_CTRL, 32'h20FE);
		refuse(`BCS_REG_CTRL, 32'h21FF);
		axi_wr(32'h40, 32'h0, 2'h2);
		axi_rd(32'h40, d, r);
		check("read response", 32'(r), 32'h2);
		$display("test refusals done");
		test_done();
	end
endmodule : testbench
